// >>> adc_port_pkg.sv
package adc_port_pkg;

	// ****************************************************************
	// Widths and pipeline
	// ****************************************************************
	localparam int DATA_W       = 10;
	localparam int PIPE_LATENCY = 5;
	localparam int PIN_W        = 8;

	// ****************************************************************
	// Register map (byte addresses) and fields
	// ****************************************************************
	localparam logic [7:0]  CTRL_OFF      = 8'h00;
	localparam logic [7:0]  STATUS_OFF    = 8'h04;
	localparam logic [7:0]  IRQ_STAT_OFF  = 8'h08;
	localparam logic [7:0]  IRQ_MASK_OFF  = 8'h0c;
	localparam logic [7:0]  COUNT_OFF     = 8'h10;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0001;
	localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
	localparam int          CTRL_EN_BIT   = 0;
	localparam int          IRQ_OUT_BIT   = 0;
	localparam int          IRQ_RANGE_BIT = 1;
	localparam int          IRQ_W         = 2;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [1:0] {
		STYLE_FULL       = 2'b00,
		STYLE_DEMUX_SIM  = 2'b01,
		STYLE_DEMUX_INTL = 2'b10,
		STYLE_LVDS       = 2'b11
	} style_t;

	typedef enum logic [1:0] {
		PWR_RUN     = 2'b00,
		PWR_OUT_OFF = 2'b01,
		PWR_NAP     = 2'b10,
		PWR_SLEEP   = 2'b11
	} power_t;

	typedef struct packed {
		logic              range;
		logic [DATA_W-1:0] code;
	} sample_t;

	typedef struct packed {
		logic twos;
		logic stab;
	} fmt_t;

	// Four-level format strap: 0, 1/3, 2/3, full supply
	function automatic fmt_t decode_format(input logic [1:0] lvl);
		fmt_t f;
		f.twos = lvl[1];
		f.stab = lvl[1] ^ lvl[0];
		return f;
	endfunction : decode_format

	function automatic power_t decode_power(input logic pd,
		input logic oe_n);
		return power_t'({pd, oe_n});
	endfunction : decode_power

endpackage : adc_port_pkg

// >>> sample_delay_line.sv
// Shift line that advances only on conversion starts, so its latency
// counts encode cycles rather than clock cycles.
module sample_delay_line #(
	parameter int WIDTH = 11,
	parameter int DEPTH = 5
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             advance,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);

	logic [WIDTH-1:0] stage [DEPTH];

	// ****************************************************************
	// Stages
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				stage[i] <= '0;
			end
		end else if (advance) begin
			stage[0] <= din;
			for (int i = 1; i < DEPTH; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	assign dout = stage[DEPTH-1];

endmodule : sample_delay_line

// >>> adc_cmos_output_port.sv
module adc_cmos_output_port
	import adc_port_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              srst,
	input  wire logic [7:0]        s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [7:0]        s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              encode_pos,
	input  wire logic              encode_neg,
	input  wire logic              power_down_select,
	input  wire logic              output_enable_n,
	input  wire logic [1:0]        style_strap,
	input  wire logic [1:0]        format_strap,
	input  wire logic [DATA_W-1:0] quantizer_code,
	input  wire logic              quantizer_over,
	input  wire logic              quantizer_under,
	output logic [DATA_W-1:0]      first_bus_data,
	output logic                   first_bus_data_oe,
	output logic                   first_bus_range_flag,
	output logic                   first_bus_range_flag_oe,
	output logic                   first_bus_strobe,
	output logic                   first_bus_strobe_oe,
	output logic [DATA_W-1:0]      second_bus_data,
	output logic                   second_bus_data_oe,
	output logic                   second_bus_range_flag,
	output logic                   second_bus_range_flag_oe,
	output logic                   second_bus_strobe,
	output logic                   second_bus_strobe_oe,
	output logic                   irq
);

	logic [PIN_W-1:0] pin_meta;
	logic [PIN_W-1:0] pin_sync;
	logic             enc_prev;
	logic             enc_level;
	logic             enc_rise;
	logic             enc_fall;
	style_t           style;
	fmt_t             fmt;
	power_t           power;
	logic             running;
	logic             convert;
	logic             phase;
	sample_t          pipe_in;
	sample_t          pipe_out;
	sample_t          hold;
	logic [31:0]      ctrl;
	logic [31:0]      irq_mask;
	logic [IRQ_W-1:0] irq_stat;
	logic [31:0]      conv_count;
	logic             aw_full;
	logic             w_full;
	logic [7:0]       wr_addr;
	logic [31:0]      wr_data;
	logic [3:0]       wr_strb;
	logic             do_write;
	logic [31:0]      rd_word;
	logic [1:0]       rd_resp;
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;
	logic             drive;

	// ****************************************************************
	// Pin synchronisers and encode edge detection
	// ****************************************************************
	// Two stages; only the second stage feeds any logic
	always_ff @(posedge clk) begin
		pin_meta <= {encode_pos, encode_neg, power_down_select,
			output_enable_n, style_strap, format_strap};
		pin_sync <= pin_meta;
	end

	// Differential encode: high while the true side is above
	assign enc_level = pin_sync[7] & ~pin_sync[6];

	always_ff @(posedge clk) begin
		if (srst) begin
			enc_prev <= 1'b0;
		end else begin
			enc_prev <= enc_level;
		end
	end

	assign enc_rise = enc_level & ~enc_prev;
	assign enc_fall = ~enc_level & enc_prev;

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	assign style = style_t'(pin_sync[3:2]);
	assign fmt   = decode_format(pin_sync[1:0]);
	assign power = decode_power(pin_sync[5], pin_sync[4]);
	// Nap and sleep stop the converter; output disable does not
	assign running = ((power == PWR_RUN) || (power == PWR_OUT_OFF))
		&& ctrl[CTRL_EN_BIT];
	assign convert = enc_rise & running;

	// Offset binary from the core; flipping the MSB gives two's
	// complement, so midscale codes all-ones and all-zeros meet
	assign pipe_in.code = quantizer_code
		^ {fmt.twos, {(DATA_W-1){1'b0}}};
	assign pipe_in.range = quantizer_over | quantizer_under;

	sample_delay_line #(
		.WIDTH ($bits(sample_t)),
		.DEPTH (PIPE_LATENCY)
	) u_delay (
		.clk     (clk),
		.srst    (srst),
		.advance (convert),
		.din     (pipe_in),
		.dout    (pipe_out)
	);

	// ****************************************************************
	// Output steering
	// ****************************************************************
	// Phase picks which bus takes the sample in demux modes
	always_ff @(posedge clk) begin
		if (srst) begin
			phase <= 1'b0;
		end else if (convert) begin
			phase <= ~phase;
		end
	end

	// Bus data and range flags
	always_ff @(posedge clk) begin
		if (srst) begin
			first_bus_data        <= '0;
			first_bus_range_flag  <= 1'b0;
			second_bus_data       <= '0;
			second_bus_range_flag <= 1'b0;
			hold                  <= '0;
		end else if (convert) begin
			unique case (style)
				STYLE_FULL, STYLE_LVDS: begin
					first_bus_data       <= pipe_out.code;
					first_bus_range_flag <= pipe_out.range;
				end
				STYLE_DEMUX_INTL: begin
					if (!phase) begin
						first_bus_data       <= pipe_out.code;
						first_bus_range_flag <= pipe_out.range;
					end else begin
						second_bus_data       <= pipe_out.code;
						second_bus_range_flag <= pipe_out.range;
					end
				end
				STYLE_DEMUX_SIM: begin
					// Older sample waits so both buses change together
					if (!phase) begin
						hold <= pipe_out;
					end else begin
						first_bus_data        <= hold.code;
						first_bus_range_flag  <= hold.range;
						second_bus_data       <= pipe_out.code;
						second_bus_range_flag <= pipe_out.range;
					end
				end
			endcase
		end
	end

	// Strobes: data is stable at the edge the receiver latches on
	always_ff @(posedge clk) begin
		if (srst) begin
			first_bus_strobe  <= 1'b0;
			second_bus_strobe <= 1'b0;
		end else if (style == STYLE_FULL || style == STYLE_LVDS) begin
			if (convert) begin
				first_bus_strobe  <= 1'b1;
				second_bus_strobe <= 1'b1;
			end else if (enc_fall) begin
				first_bus_strobe  <= 1'b0;
				second_bus_strobe <= 1'b0;
			end
		end else if (convert && style == STYLE_DEMUX_SIM) begin
			// Both buses change on the odd sample; the latching strobe
			// edges come on the sample after, so no latching edge meets new data
			first_bus_strobe  <= phase;
			second_bus_strobe <= ~phase;
		end else if (convert) begin
			first_bus_strobe  <= ~phase;
			second_bus_strobe <= phase;
		end
	end

	// Output enables
	assign drive = (style != STYLE_LVDS) && (power == PWR_RUN);

	always_ff @(posedge clk) begin
		if (srst) begin
			first_bus_data_oe        <= 1'b0;
			first_bus_range_flag_oe  <= 1'b0;
			first_bus_strobe_oe      <= 1'b0;
			second_bus_data_oe       <= 1'b0;
			second_bus_range_flag_oe <= 1'b0;
			second_bus_strobe_oe     <= 1'b0;
		end else begin
			first_bus_data_oe        <= drive;
			first_bus_range_flag_oe  <= drive;
			first_bus_strobe_oe      <= drive;
			second_bus_data_oe       <= drive && style != STYLE_FULL;
			second_bus_range_flag_oe <= drive && style != STYLE_FULL;
			second_bus_strobe_oe     <= drive;
		end
	end

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************
	assign do_write = aw_full && w_full && !s_axi_bvalid;

	// Write channels are taken in either order, answered after both
	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			aw_full       <= 1'b0;
			w_full        <= 1'b0;
			wr_addr       <= '0;
			wr_data       <= '0;
			wr_strb       <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				s_axi_awready <= 1'b0;
				aw_full       <= 1'b1;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				s_axi_wready <= 1'b0;
				w_full       <= 1'b1;
				wr_data      <= s_axi_wdata;
				wr_strb      <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_addr == CTRL_OFF
					|| wr_addr == IRQ_STAT_OFF
					|| wr_addr == IRQ_MASK_OFF) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// Read decode; unmapped addresses answer zero with SLVERR
	always_comb begin
		rd_word = '0;
		rd_resp = RESP_OKAY;
		unique case (s_axi_araddr)
			CTRL_OFF:     rd_word = ctrl;
			STATUS_OFF:   rd_word = {26'h0, power, fmt.stab, fmt.twos,
				style};
			IRQ_STAT_OFF: rd_word = {{(32-IRQ_W){1'b0}}, irq_stat};
			IRQ_MASK_OFF: rd_word = irq_mask;
			COUNT_OFF:    rd_word = conv_count;
			default:      rd_resp = RESP_SLVERR;
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_word;
			s_axi_rresp   <= rd_resp;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Byte-lane write of control and mask
	always_ff @(posedge clk) begin
		if (srst) begin
			ctrl     <= CTRL_RESET;
			irq_mask <= MASK_RESET;
		end else if (do_write) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_strb[b] && wr_addr == CTRL_OFF) begin
					ctrl[b*8 +: 8] <= wr_data[b*8 +: 8];
				end
				if (wr_strb[b] && wr_addr == IRQ_MASK_OFF) begin
					irq_mask[b*8 +: 8] <= wr_data[b*8 +: 8];
				end
			end
		end
	end

	// Conversion counter, readable state of the converter
	always_ff @(posedge clk) begin
		if (srst) begin
			conv_count <= '0;
		end else if (convert) begin
			conv_count <= conv_count + 32'd1;
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	assign irq_set = {convert & pipe_out.range, convert};
	assign irq_clr = (do_write && wr_addr == IRQ_STAT_OFF && wr_strb[0])
		? wr_data[IRQ_W-1:0] : '0;

	// A new event wins over a clear in the same cycle
	always_ff @(posedge clk) begin
		if (srst) begin
			irq_stat <= '0;
			irq      <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			irq      <= |(irq_stat & irq_mask[IRQ_W-1:0]);
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	property p_conv_start;
		enc_rise && running |=> conv_count == $past(conv_count) + 32'd1;
	endproperty
	a_conv_start: assert property (p_conv_start)
		else $error("conversion not started on encode rise");
	// Enables follow the reset release one cycle late
	property p_run_drive;
		!srst && power == PWR_RUN && style != STYLE_LVDS |=>
			first_bus_data_oe && first_bus_strobe_oe;
	endproperty
	a_run_drive: assert property (p_run_drive)
		else $error("outputs not driven in normal operation");
	property p_out_off;
		power == PWR_OUT_OFF |=> !first_bus_data_oe && !second_bus_strobe_oe;
	endproperty
	a_out_off: assert property (p_out_off)
		else $error("outputs driven while output enable is off");
	property p_nap;
		power == PWR_NAP |=> !first_bus_data_oe && !convert;
	endproperty
	a_nap: assert property (p_nap)
		else $error("nap mode not honoured");
	property p_sleep;
		power == PWR_SLEEP ##1 power == PWR_SLEEP |->
			!first_bus_strobe_oe && $stable(conv_count);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep mode not honoured");
	property p_b_data_off;
		style == STYLE_FULL |=> !second_bus_data_oe;
	endproperty
	a_b_data_off: assert property (p_b_data_off)
		else $error("second bus data driven in full rate");
	property p_b_flag_off;
		style == STYLE_FULL |=> !second_bus_range_flag_oe;
	endproperty
	a_b_flag_off: assert property (p_b_flag_off)
		else $error("second range flag driven in full rate");
	property p_b_strobe_on;
		!srst && style == STYLE_FULL && power == PWR_RUN |=>
			second_bus_strobe_oe;
	endproperty
	a_b_strobe_on: assert property (p_b_strobe_on)
		else $error("second strobe released in full rate");
	property p_a_bus;
		convert && style == STYLE_FULL |=> first_bus_data ==
			$past(pipe_out.code) && first_bus_range_flag ==
			$past(pipe_out.range);
	endproperty
	a_a_bus: assert property (p_a_bus)
		else $error("first bus does not carry the sample");
	property p_style;
		style == STYLE_LVDS |=> !first_bus_data_oe
			&& !first_bus_strobe_oe && !second_bus_strobe_oe;
	endproperty
	a_style: assert property (p_style)
		else $error("output style strap misdecoded");
	property p_format;
		fmt.twos == pin_sync[1] && fmt.stab == (pin_sync[1:0] == 2'b01
			|| pin_sync[1:0] == 2'b10);
	endproperty
	a_format: assert property (p_format)
		else $error("format strap misdecoded");
	property p_twos;
		fmt.twos |-> pipe_in.code == {~quantizer_code[DATA_W-1],
			quantizer_code[DATA_W-2:0]};
	endproperty
	a_twos: assert property (p_twos)
		else $error("two's complement code wrong");
	property p_alternate;
		convert && style == STYLE_DEMUX_INTL && phase |=>
			$stable(first_bus_data) && second_bus_strobe
			&& !first_bus_strobe;
	endproperty
	a_alternate: assert property (p_alternate)
		else $error("demux samples not alternating");
	property p_full_strobe;
		convert && style == STYLE_FULL |=> first_bus_strobe;
	endproperty
	a_full_strobe: assert property (p_full_strobe)
		else $error("no strobe for full-rate sample");

	c_full: cover property (convert && style == STYLE_FULL
		&& first_bus_data_oe);
	c_intl: cover property (convert && style == STYLE_DEMUX_INTL && phase);
	c_sim: cover property (convert && style == STYLE_DEMUX_SIM && phase);
	c_irq: cover property (irq && pipe_out.range);

endmodule : adc_cmos_output_port

// >>> adc_capture_model.sv
module adc_capture_model
	import adc_port_pkg::*;
(
	input  wire logic       clk,
	input  wire style_t     mode,
	input  wire sample_t    a_val,
	input  wire logic [1:0] a_oe,
	input  wire logic       a_strb,
	input  wire logic       a_strb_oe,
	input  wire sample_t    b_val,
	input  wire logic [1:0] b_oe,
	input  wire logic       b_strb,
	input  wire logic       b_strb_oe
);
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************************
	// Receiver capture
	// ****************************************************************
	sample_t cap_q[$];
	sample_t a_line;
	sample_t b_line;
	logic    a_prev = 1'b0;
	logic    b_prev = 1'b0;
	logic    b_edge;

	// Released lines read as the inverse of the driven value
	assign a_line.range = a_oe[1] ? a_val.range : ~a_val.range;
	assign a_line.code  = a_oe[0] ? a_val.code : ~a_val.code;
	assign b_line.range = b_oe[1] ? b_val.range : ~b_val.range;
	assign b_line.code  = b_oe[0] ? b_val.code : ~b_val.code;

	// Second bus edge depends on the update style
	assign b_edge = (mode == STYLE_DEMUX_SIM) ? (b_strb && !b_prev)
		: (!b_strb && b_prev);

	// Same-edge captures put the first bus first, keeping sample order
	always @(posedge clk) begin
		a_prev <= a_strb;
		b_prev <= b_strb;
		if (a_strb_oe && a_prev && !a_strb) begin
			cap_q.push_back(a_line);
		end
		if (b_strb_oe && mode != STYLE_FULL && b_edge) begin
			cap_q.push_back(b_line);
		end
	end

endmodule : adc_capture_model

// >>> testbench.sv
module testbench
	import adc_port_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************************************
	// Signals and model state
	// ****************************************************************
	localparam int NC = 16;
	logic              clk = 1'b0;
	logic              srst = 1'b1;
	logic [7:0]        s_axi_awaddr = 8'h00;
	logic              s_axi_awvalid = 1'b0;
	logic              s_axi_awready;
	logic [31:0]       s_axi_wdata = 32'h0;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic              s_axi_wvalid = 1'b0;
	logic              s_axi_wready;
	logic [1:0]        s_axi_bresp;
	logic              s_axi_bvalid;
	logic              s_axi_bready = 1'b0;
	logic [7:0]        s_axi_araddr = 8'h00;
	logic              s_axi_arvalid = 1'b0;
	logic              s_axi_arready;
	logic [31:0]       s_axi_rdata;
	logic [1:0]        s_axi_rresp;
	logic              s_axi_rvalid;
	logic              s_axi_rready = 1'b0;
	logic              encode_pos = 1'b0;
	logic              encode_neg = 1'b1;
	logic              power_down_select = 1'b0;
	logic              output_enable_n = 1'b0;
	style_t            style_strap = STYLE_FULL;
	logic [1:0]        format_strap = 2'h0;
	logic [DATA_W-1:0] quantizer_code = 10'h000;
	logic              quantizer_over = 1'b0;
	logic              quantizer_under = 1'b0;
	logic [DATA_W-1:0] first_bus_data;
	logic [DATA_W-1:0] second_bus_data;
	logic              first_bus_data_oe, first_bus_range_flag;
	logic              first_bus_range_flag_oe, first_bus_strobe;
	logic              first_bus_strobe_oe, second_bus_data_oe;
	logic              second_bus_range_flag, second_bus_range_flag_oe;
	logic              second_bus_strobe, second_bus_strobe_oe, irq;
	int                error_cnt = 0;
	int                checks = 0;
	int                seed = 32'hcad5b205;
	int                enc_left = 0;
	logic [31:0]       rnd;
	logic [31:0]       rd;
	logic [1:0]        rr;
	sample_t           m;
	sample_t           smp[$];
	style_t            seg_style[8] = '{STYLE_FULL, STYLE_FULL,
		STYLE_DEMUX_SIM, STYLE_DEMUX_INTL, STYLE_FULL, STYLE_DEMUX_INTL,
		STYLE_DEMUX_SIM, STYLE_LVDS};
	logic [1:0]        seg_fmt[8] = '{2'h0, 2'h2, 2'h1, 2'h3, 2'h0, 2'h0,
		2'h0, 2'h2};
	logic [1:0]        seg_pwr[8] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h2,
		2'h3, 2'h0};
	wire logic [2:0]   a_oes = {first_bus_data_oe, first_bus_range_flag_oe,
		first_bus_strobe_oe};
	wire logic [1:0]   b_oes = {second_bus_data_oe, second_bus_range_flag_oe};

	`define CHK(nm, e, g) \
		begin \
			checks++; \
			if ((g) !== (e)) begin \
				error_cnt++; \
				$display("[ERR] %s exp %h got %h", nm, (e), (g)); \
			end \
		end

	adc_cmos_output_port uut (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .encode_pos, .encode_neg,
		.power_down_select, .output_enable_n, .style_strap, .format_strap,
		.quantizer_code, .quantizer_over, .quantizer_under, .first_bus_data,
		.first_bus_data_oe, .first_bus_range_flag, .first_bus_range_flag_oe,
		.first_bus_strobe, .first_bus_strobe_oe, .second_bus_data,
		.second_bus_data_oe, .second_bus_range_flag,
		.second_bus_range_flag_oe, .second_bus_strobe,
		.second_bus_strobe_oe, .irq);

	adc_capture_model rx (.clk, .mode(style_strap),
		.a_val({first_bus_range_flag, first_bus_data}),
		.a_oe({first_bus_range_flag_oe, first_bus_data_oe}),
		.a_strb(first_bus_strobe), .a_strb_oe(first_bus_strobe_oe),
		.b_val({second_bus_range_flag, second_bus_data}),
		.b_oe({second_bus_range_flag_oe, second_bus_data_oe}),
		.b_strb(second_bus_strobe), .b_strb_oe(second_bus_strobe_oe));

	// ****************************************************************
	// Stimulus processes
	// ****************************************************************
	always #4 clk = ~clk;

	// Encode runs only for a burst and rests low between bursts
	always begin
		#80;
		if (enc_left > 0 || encode_pos) begin
			encode_pos = ~encode_pos;
			encode_neg = ~encode_pos;
			if (encode_pos) enc_left--;
		end
	end

	// New core result after each encode fall, stable through the next rise
	always @(negedge encode_pos) begin
		@(posedge clk);
		rnd = $random(seed);
		quantizer_code <= rnd[DATA_W-1:0];
		quantizer_over <= rnd[31:29] == 3'h0;
		quantizer_under <= rnd[28:26] == 3'h7;
	end

	// Reference result for each encode rise, formatted as strapped
	always @(posedge encode_pos) begin
		m.code = quantizer_code ^ {format_strap[1], {(DATA_W-1){1'b0}}};
		m.range = quantizer_over | quantizer_under;
		smp.push_back(m);
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		rr = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axw

	task automatic axr(input logic [7:0] a);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axr

	// Reset resets the pipe and phase, so each mode starts from a known state
	task automatic run_seg(input style_t st, input logic [1:0] fm,
		input logic [1:0] pw);
		int   n;
		int   skip;
		logic drive;
		@(posedge clk);
		srst <= 1'b1;
		style_strap <= st;
		format_strap <= fm;
		power_down_select <= pw[1];
		output_enable_n <= pw[0];
		repeat (20) @(posedge clk);
		srst <= 1'b0;
		repeat (5) @(posedge clk);
		smp.delete();
		rx.cap_q.delete();
		enc_left = NC;
		wait (enc_left == 0 && !encode_pos);
		repeat (10) @(posedge clk);
		n = rx.cap_q.size();
		drive = st != STYLE_LVDS && pw == 2'b00;
		axr(COUNT_OFF);
		`CHK("count", pw[1] ? 32'h0 : 32'(NC), rd);
		axr(STATUS_OFF);
		`CHK("status", {26'h0, pw, fm[1] ^ fm[0], fm[1], st}, rd);
		`CHK("a_oe", {3{drive}}, a_oes);
		`CHK("b_oe", {2{drive && st != STYLE_FULL}}, b_oes);
		`CHK("b_strobe_oe", drive, second_bus_strobe_oe);
		`CHK("ncap", 1'b1, drive ? n + 1 >= NC && n <= NC : n == 0);
		// The first five results are reset contents of the pipe;
		// simultaneous mode first latches the idle second bus as well
		skip = (st == STYLE_DEMUX_SIM) ? 6 : 5;
		for (int i = skip; i < n; i++) begin
			`CHK("sample", smp[i - skip], rx.cap_q[i]);
		end
	endtask : run_seg

	task automatic end_sim();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		for (int i = 0; i < 8; i++) begin
			run_seg(seg_style[i], seg_fmt[i], seg_pwr[i]);
		end
		axr(CTRL_OFF);
		`CHK("ctrl", CTRL_RESET, rd);
		axr(IRQ_MASK_OFF);
		`CHK("mask", MASK_RESET, rd);
		`CHK("irq_masked", 1'b0, irq);
		axw(IRQ_MASK_OFF, 32'h1);
		repeat (3) @(posedge clk);
		`CHK("irq_on", 1'b1, irq);
		axw(IRQ_STAT_OFF, 32'h3);
		repeat (3) @(posedge clk);
		`CHK("irq_off", 1'b0, irq);
		axr(IRQ_STAT_OFF);
		`CHK("stat", 32'h0, rd);
		axw(STATUS_OFF, 32'hffff_ffff);
		`CHK("ro_resp", RESP_SLVERR, rr);
		axr(8'h40);
		`CHK("bad_resp", {RESP_SLVERR, 32'h0}, {rr, rd});
		// Conversion disabled: a burst must leave the count alone
		axw(CTRL_OFF, 32'h0);
		`CHK("ctrl_resp", RESP_OKAY, rr);
		enc_left = 4;
		wait (enc_left == 0 && !encode_pos);
		repeat (10) @(posedge clk);
		axr(COUNT_OFF);
		`CHK("frozen", 32'(NC), rd);
		`CHK("irq_idle", 1'b0, irq);
		end_sim();
	end

	// Watchdog well past nine bursts of up to about 320 clocks each
	initial begin
		#400000;
		error_cnt++;
		end_sim();
	end

endmodule : testbench
